// ==== dtp_defs.svh ====
// Purpose: Constants for the trigger and pacing control block
// Assumes: 100 MHz ref_clk_i
// Notes: Offsets are byte addresses on the plain register port
`ifndef DTP_DEFS_SVH
`define DTP_DEFS_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define DTP_CLK_MHZ 100
`define DTP_PULSE_NS 50
`define DTP_UPD_OUT_NS 225
`define DTP_CONV_GAP_NS 5000
`define DTP_UPD_LAT_NS 100
`define DTP_PULSE_CYC ((`DTP_PULSE_NS * `DTP_CLK_MHZ + 999) / 1000)
`define DTP_UPD_OUT_CYC ((`DTP_UPD_OUT_NS * `DTP_CLK_MHZ + 999) / 1000)
`define DTP_CONV_GAP_CYC ((`DTP_CONV_GAP_NS * `DTP_CLK_MHZ + 999) / 1000)
`define DTP_UPD_LAT_CYC ((`DTP_UPD_LAT_NS * `DTP_CLK_MHZ) / 1000)

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define DTP_REG_CTRL 6'h00
`define DTP_REG_AI_SEL 6'h04
`define DTP_REG_AO_SEL 6'h08
`define DTP_REG_OUT_SEL 6'h0C
`define DTP_REG_AI_DIV 6'h10
`define DTP_REG_CHANS 6'h14
`define DTP_REG_POST 6'h18
`define DTP_REG_STATUS 6'h1C
`define DTP_REG_AO_DIV 6'h20
`define DTP_REG_CMD 6'h24

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define DTP_CTRL_PRETRIG 1
`define DTP_CTRL_EXT_CONV 2
`define DTP_CTRL_SW_GATE 3
`define DTP_CTRL_AI_EXT_TB 4
`define DTP_CTRL_AO_EXT_TB 6
`define DTP_CTRL_GATE_EN 7
`define DTP_CTRL_AO_EXT_UPD 8
`define DTP_CMD_AI_ARM 0
`define DTP_CMD_AI_DISARM 1
`define DTP_CMD_AO_ARM 2
`define DTP_CMD_AO_DISARM 3
`define DTP_AI_SEL_RST 16'h5002
`define DTP_AO_SEL_RST 13'h0034
`define DTP_OUT_SEL_RST 10'h0000
`define DTP_SRC_HDR 3'h6
`define DTP_HDR_STOP 4'h6
`define DTP_HDR_CONV 4'h7
`define DTP_HDR_AOST 4'h8
`define DTP_HDR_NONE 4'hF
`endif

// ==== dtp_ext_model.sv ====
// Purpose: External trigger, strobe and time base sources for the block
// Assumes: Shares the board time base with the device
// Notes: Index 0-5 aux inputs, 6 stop, 7 convert, 8 output start header
`default_nettype none
module dtp_ext_model (
    input wire logic ref_clk_i,
    output logic [5:0] aux_input_pin_o,
    output logic hdr_acq_stop_in_o,
    output logic hdr_adc_conv_in_o,
    output logic hdr_dac_start_in_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] lvl = 9'h000;
    logic tb_run = 1'b0;
    logic tb_lvl = 1'b0;
    int ph = 0;
    int cyc = 0;
    int last = -20000;
    int edge_cyc = 0;

    assign aux_input_pin_o = lvl[5:0] ^ {tb_lvl, 5'h00};
    assign hdr_acq_stop_in_o = lvl[6];
    assign hdr_adc_conv_in_o = lvl[7];
    assign hdr_dac_start_in_o = lvl[8];

    // ------------------------------------------------------------------
    // Time base on input 5: 30 ns phases, 60 ns period
    // ------------------------------------------------------------------
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        ph <= (ph == 2) ? 0 : ph + 1;
        if (tb_run && ph == 2) begin
            tb_lvl <= ~tb_lvl;
        end
    end

    // Keeps at least gap cycles since the previous edge of any source
    task automatic flip(input int i, input int gap);
        while (cyc - last < gap) begin
            @(posedge ref_clk_i);
        end
        @(posedge ref_clk_i);
        lvl[i] <= ~lvl[i];
        last = cyc;
    endtask

    task automatic strobe(input int i, input int gap);
        flip(i, gap);
        edge_cyc = cyc;
        repeat (3) @(posedge ref_clk_i);
        flip(i, 0);
    endtask
endmodule
`default_nettype wire

// ==== dtp_pkg.sv ====
// Purpose: Types for the trigger and pacing control block
// Assumes: Nothing beyond the defs header
// Notes: One-hot state codes
`default_nettype none
package dtp_pkg;
    typedef enum logic [1:0] {S_IDLE = 2'b01, S_SCAN = 2'b10} dtp_scan_t;
    typedef enum logic [2:0] {
        A_IDLE = 3'b001, A_PRE = 3'b010, A_POST = 3'b100
    } dtp_acq_t;
    typedef enum logic [2:0] {
        O_IDLE = 3'b001, O_WAIT = 3'b010, O_RUN = 3'b100
    } dtp_ao_t;
endpackage
`default_nettype wire

// ==== dtp_trigger_pacing.sv ====
// Purpose: Trigger, pacing and strobe control for analog in and out
// Assumes: Inputs synchronous to ref_clk_i; clock is the board time base
// Notes: Registers on a plain port, read data one cycle after strobe
// Behaviour
// - Pre-trigger mode stores circularly until post count
// - Stop trigger source selectable, default input 2
// - Chosen stop edge starts post-trigger counting
// - Routed stop trigger is 50 ns high pulse
// - Scan begin pulse 50 ns at scan start
// - Sample-hold polar, whole scan when chans above 1, drops at last
// - Convert strobe source and polarity selectable, routable
// - External convert edge starts one conversion
// - Internal pacer converts, gated by hardware or software
// - Active gate holds off scans, finishes current scan
// - Input pacer may use external polar time base
// - Acquisition done gives 50 ns routable pulse
// - Output start edge starts waveform generation
// - Routed output start is 50 ns high pulse
// - Each update edge updates outputs within 100 ns
// - Routed update strobe is 230 ns polar pulse
// - Output pacer may use external limited time base
// - All timing derives from one time base
`include "dtp_defs.svh"
`default_nettype none
module dtp_trigger_pacing (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic [5:0] aux_input_pin_i,
    input wire logic hdr_acq_stop_in_i,
    input wire logic hdr_adc_conv_in_i,
    input wire logic hdr_dac_start_in_i,
    input wire logic [5:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    output logic [2:0] aux_output_pin_o,
    output logic adc_conv_o,
    output logic [12:0] buf_addr_o,
    output logic dac_update_o
);
    import dtp_pkg::*;

    // ------------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------------
    logic [8:0] ctrl;
    logic [15:0] ai_sel;
    logic [12:0] ao_sel;
    logic [9:0] out_sel;
    logic [15:0] ai_div, ao_div, ai_pc, ao_pc;
    logic [7:0] chans, conv_left;
    logic [23:0] post_cnt, post_left;
    logic [9:0] gap;
    logic [12:0] buf_addr;
    logic pace_pend;
    dtp_scan_t scan_state;
    dtp_acq_t acq_state;
    dtp_ao_t ao_state;
    logic [8:0] in_s1, in_s2;
    logic [5:0] lv_q;
    logic [4:0] pc [5];

    localparam int P_STOP = 0;
    localparam int P_SCAN = 1;
    localparam int P_DONE = 2;
    localparam int P_AOST = 3;
    localparam int P_UPD = 4;

    function automatic logic pick(input logic [8:0] v, input logic [2:0] s,
                                  input logic [3:0] hdr);
        logic r;
        r = 1'b0;
        if (s < `DTP_SRC_HDR)
            r = v[s];
        else if (hdr != `DTP_HDR_NONE)
            r = v[hdr];
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Input selection, polarity and edges
    // ------------------------------------------------------------------
    wire [8:0] raw = {hdr_dac_start_in_i, hdr_adc_conv_in_i,
                      hdr_acq_stop_in_i, aux_input_pin_i};
    wire stop_lv = pick(in_s2, ai_sel[2:0], `DTP_HDR_STOP) ^ ai_sel[3];
    wire conv_lv = pick(in_s2, ai_sel[6:4], `DTP_HDR_CONV) ^ ai_sel[7];
    wire gate_lv = pick(in_s2, ai_sel[10:8], `DTP_HDR_NONE) ^ ai_sel[11];
    wire aitb_lv = pick(in_s2, ai_sel[14:12], `DTP_HDR_NONE) ^ ai_sel[15];
    wire aost_lv = pick(in_s2, ao_sel[2:0], `DTP_HDR_AOST) ^ ao_sel[3];
    wire upd_lv = pick(in_s2, ao_sel[6:4], `DTP_HDR_NONE) ^ ao_sel[7];
    wire aotb_lv = pick(in_s2, ao_sel[10:8], `DTP_HDR_NONE) ^ ao_sel[11];
    wire [5:0] lv = {aotb_lv, upd_lv, aost_lv, aitb_lv, conv_lv, stop_lv};
    wire [5:0] rise = lv & ~lv_q;
    wire stop_edge = rise[0];
    wire conv_edge = rise[1];

    // ------------------------------------------------------------------
    // Register port decode
    // ------------------------------------------------------------------
    wire wr_ctrl = reg_wr_i && reg_addr_i == `DTP_REG_CTRL;
    wire wr_cmd = reg_wr_i && reg_addr_i == `DTP_REG_CMD;
    wire ai_arm = wr_cmd && reg_wdata_i[`DTP_CMD_AI_ARM];
    wire ai_disarm = wr_cmd && reg_wdata_i[`DTP_CMD_AI_DISARM];
    wire ao_arm = wr_cmd && reg_wdata_i[`DTP_CMD_AO_ARM];
    wire ao_disarm = wr_cmd && reg_wdata_i[`DTP_CMD_AO_DISARM];
    wire gate_on = ctrl[`DTP_CTRL_SW_GATE]
                   | (ctrl[`DTP_CTRL_GATE_EN] & gate_lv);
    wire [31:0] status = {21'h0, ao_state, acq_state, scan_state,
                          pace_pend, gate_on, post_left == 24'h0};
    logic [31:0] rd_mux;
    always_comb begin
        case (reg_addr_i)
            `DTP_REG_CTRL: rd_mux = {23'h0, ctrl};
            `DTP_REG_AI_SEL: rd_mux = {16'h0, ai_sel};
            `DTP_REG_AO_SEL: rd_mux = {19'h0, ao_sel};
            `DTP_REG_OUT_SEL: rd_mux = {22'h0, out_sel};
            `DTP_REG_AI_DIV: rd_mux = {16'h0, ai_div};
            `DTP_REG_CHANS: rd_mux = {24'h0, chans};
            `DTP_REG_POST: rd_mux = {8'h0, post_cnt};
            `DTP_REG_STATUS: rd_mux = status;
            `DTP_REG_AO_DIV: rd_mux = {16'h0, ao_div};
            default: rd_mux = 32'h0;
        endcase
    end

    // ------------------------------------------------------------------
    // Analog input pacing and scan control
    // ------------------------------------------------------------------
    wire ext_conv = ctrl[`DTP_CTRL_EXT_CONV];
    wire acq_run = acq_state != A_IDLE;
    // Clock itself is the internal time base
    wire ai_tick = ctrl[`DTP_CTRL_AI_EXT_TB] ? rise[2] : 1'b1;
    wire ao_tick = ctrl[`DTP_CTRL_AO_EXT_TB] ? rise[5] : 1'b1;
    wire pace_hit = ai_tick && ai_pc == 16'h0;
    wire scan_start = scan_state == S_IDLE && acq_run
                      && (ext_conv ? conv_edge
                          : (pace_pend && !gate_on));
    wire next_conv = ext_conv ? conv_edge : gap == 10'h0;
    wire conv_in_scan = scan_state == S_SCAN && acq_run && next_conv;
    wire conv_go = scan_start || conv_in_scan;
    wire last_conv = scan_start ? chans <= 8'h1 : conv_left == 8'h1;
    wire post_end = acq_state == A_POST && conv_go && post_left <= 24'h1;
    wire acq_done = post_end || (acq_run && ai_disarm);

    // ------------------------------------------------------------------
    // Analog output trigger and update
    // ------------------------------------------------------------------
    wire ao_start = ao_state == O_WAIT && rise[3];
    wire upd_go = ao_state == O_RUN
                  && (ctrl[`DTP_CTRL_AO_EXT_UPD] ? rise[4]
                      : (ao_tick && ao_pc == 16'h0));

    // ------------------------------------------------------------------
    // Pulse stretchers and output routing
    // ------------------------------------------------------------------
    wire [4:0] pt = {upd_go, ao_start, acq_done, scan_start,
                     stop_edge && acq_state == A_PRE};
    logic [4:0] pl;
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_pulse
            localparam logic [4:0] W = (gi == P_UPD)
                ? 5'(`DTP_UPD_OUT_CYC) : 5'(`DTP_PULSE_CYC);
            assign pl[gi] = pc[gi] != 5'h0;
            always_ff @(posedge ref_clk_i) begin
                if (sys_rst_i)
                    pc[gi] <= 5'h0;
                else if (pt[gi])
                    pc[gi] <= W;
                else if (pl[gi])
                    pc[gi] <= pc[gi] - 5'h1;
            end
        end
    endgenerate
    wire ssh_lv = (scan_state == S_SCAN) ^ out_sel[9];
    wire upd_lv_out = pl[P_UPD] ^ ao_sel[12];
    wire [7:0] route_src = {upd_lv_out, pl[P_AOST], pl[P_DONE], adc_conv_o,
                            ssh_lv, pl[P_SCAN], pl[P_STOP], 1'b0};
    logic [2:0] next_aux;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_route
            assign next_aux[gi] = route_src[out_sel[3*gi +: 3]];
        end
    endgenerate
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i)
            aux_output_pin_o <= 3'h0;
        else
            aux_output_pin_o <= next_aux;
    end

    // ------------------------------------------------------------------
    // Sequential logic
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            in_s1 <= 9'h0;
            in_s2 <= 9'h0;
            lv_q <= 6'h0;
        end else begin
            in_s1 <= raw;
            in_s2 <= in_s1;
            lv_q <= lv;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            ctrl <= 9'h0;
            ai_sel <= `DTP_AI_SEL_RST;
            ao_sel <= `DTP_AO_SEL_RST;
            out_sel <= `DTP_OUT_SEL_RST;
            ai_div <= 16'h0;
            ao_div <= 16'h0;
            chans <= 8'h1;
            post_cnt <= 24'h0;
            reg_rdata_o <= 32'h0;
        end else begin
            reg_rdata_o <= reg_rd_i ? rd_mux : 32'h0;
            if (wr_ctrl)
                ctrl <= reg_wdata_i[8:0];
            if (reg_wr_i && reg_addr_i == `DTP_REG_AI_SEL)
                ai_sel <= reg_wdata_i[15:0];
            if (reg_wr_i && reg_addr_i == `DTP_REG_AO_SEL)
                ao_sel <= reg_wdata_i[12:0];
            if (reg_wr_i && reg_addr_i == `DTP_REG_OUT_SEL)
                out_sel <= reg_wdata_i[9:0];
            if (reg_wr_i && reg_addr_i == `DTP_REG_AI_DIV)
                ai_div <= reg_wdata_i[15:0];
            if (reg_wr_i && reg_addr_i == `DTP_REG_AO_DIV)
                ao_div <= reg_wdata_i[15:0];
            if (reg_wr_i && reg_addr_i == `DTP_REG_CHANS)
                chans <= reg_wdata_i[7:0];
            if (reg_wr_i && reg_addr_i == `DTP_REG_POST)
                post_cnt <= reg_wdata_i[23:0];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            ai_pc <= 16'h0;
            pace_pend <= 1'b0;
            scan_state <= S_IDLE;
            conv_left <= 8'h0;
            gap <= 10'h0;
            buf_addr <= 13'h0;
            adc_conv_o <= 1'b0;
            buf_addr_o <= 13'h0;
        end else begin
            if (ai_tick)
                ai_pc <= (ai_pc == 16'h0) ? ai_div : ai_pc - 16'h1;
            if (!acq_run)
                pace_pend <= 1'b0;
            else if (pace_hit)
                pace_pend <= 1'b1;
            else if (scan_start)
                pace_pend <= 1'b0;
            adc_conv_o <= conv_go;
            if (conv_go) begin
                buf_addr_o <= buf_addr;
                buf_addr <= buf_addr + 13'h1;
                gap <= 10'(`DTP_CONV_GAP_CYC - 1);
                conv_left <= scan_start ? chans - 8'h1 : conv_left - 8'h1;
            end else if (gap != 10'h0)
                gap <= gap - 10'h1;
            if (!acq_run || (conv_go && last_conv))
                scan_state <= S_IDLE;
            else if (scan_start)
                scan_state <= S_SCAN;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            acq_state <= A_IDLE;
            post_left <= 24'h0;
        end else if (ai_arm) begin
            acq_state <= A_PRE;
        end else if (acq_done) begin
            acq_state <= A_IDLE;
        end else if (acq_state == A_PRE && stop_edge
                     && ctrl[`DTP_CTRL_PRETRIG]) begin
            acq_state <= A_POST;
            post_left <= post_cnt;
        end else if (acq_state == A_POST && conv_go) begin
            post_left <= post_left - 24'h1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            ao_state <= O_IDLE;
            ao_pc <= 16'h0;
            dac_update_o <= 1'b0;
        end else begin
            dac_update_o <= upd_go;
            if (ao_tick)
                ao_pc <= (ao_pc == 16'h0) ? ao_div : ao_pc - 16'h1;
            case (ao_state)
                O_IDLE: if (ao_arm) ao_state <= O_WAIT;
                O_WAIT: begin
                    if (ao_disarm)
                        ao_state <= O_IDLE;
                    else if (ao_start)
                        ao_state <= O_RUN;
                end
                O_RUN: if (ao_disarm) ao_state <= O_IDLE;
                default: ao_state <= O_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    chk_circ_addr: assert property (conv_go |=>
        buf_addr == 13'($past(buf_addr) + 13'h1))
        else $error("buffer index did not advance");
    chk_stop_route: assert property (
        out_sel[2:0] == 3'h1 && pl[P_STOP] |=> aux_output_pin_o[0])
        else $error("stop trigger not routed");
    chk_post_enter: assert property (acq_state == A_PRE && stop_edge
        && ctrl[`DTP_CTRL_PRETRIG] && !ai_arm && !ai_disarm
        |=> acq_state == A_POST && post_left == $past(post_cnt))
        else $error("stop edge missed");
    chk_stop_width: assert property (pt[P_STOP] |=> pl[P_STOP][*5])
        else $error("stop pulse too short");
    chk_scan_width: assert property (scan_start |=> pl[P_SCAN][*5])
        else $error("scan pulse too short");
    chk_ssh_drop: assert property (scan_state == S_SCAN && conv_go
        && last_conv |=> scan_state == S_IDLE)
        else $error("sample-hold did not drop");
    chk_ext_conv: assert property (ext_conv && acq_run && conv_edge
        |-> conv_go ##1 adc_conv_o)
        else $error("external convert lost");
    chk_gate_hold: assert property (!ext_conv && gate_on
        |-> !scan_start)
        else $error("scan began under gate");
    chk_done_pulse: assert property (post_end && !ai_arm
        |=> acq_state == A_IDLE && pl[P_DONE])
        else $error("done pulse missing");
    chk_ao_start: assert property (ao_start && !ao_disarm
        |=> ao_state == O_RUN ##0 pl[P_AOST][*5])
        else $error("waveform start missed");
    chk_upd_out: assert property (upd_go |=> dac_update_o
        && pc[P_UPD] == 5'(`DTP_UPD_OUT_CYC))
        else $error("update pulse wrong");
    chk_ai_tb: assert property (ctrl[`DTP_CTRL_AI_EXT_TB] && !rise[2]
        |=> $stable(ai_pc))
        else $error("pacer ran without tick");

    cov_post: cover property (acq_state == A_POST ##[1:300] acq_done);
    cov_scan: cover property (scan_start ##[1:600] scan_state == S_IDLE);
    cov_upd: cover property (ao_start ##[1:300] upd_go);
endmodule
`default_nettype wire

// ==== dtp_trigger_pacing_tb.sv ====
// Purpose: Self-checking bench for the trigger and pacing block
// Assumes: External sources come from dtp_ext_model
// Notes: Registers reached through the plain strobe port
`include "dtp_defs.svh"
`default_nettype none
`define CHK(nm, exp, got) begin \
    checks++; \
    if ((got) !== (exp)) begin \
        miscompares++; \
        $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); \
    end \
end
module dtp_trigger_pacing_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [5:0] aux_in;
    logic hdr_stop, hdr_conv, hdr_start;
    logic [5:0] addr = 6'h00;
    logic [31:0] wdata = 32'h00000000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata, d;
    logic [2:0] aux_out;
    logic conv, upd;
    logic [12:0] buf_addr, ba;
    int checks = 0;
    int miscompares = 0;
    int nconv = 0;
    int nupd = 0;
    int upd_at = 0;
    int w, n, s;

    dtp_trigger_pacing dtp_trigger_pacing_inst (
        .ref_clk_i(ref_clk), .sys_rst_i(sys_rst),
        .aux_input_pin_i(aux_in), .hdr_acq_stop_in_i(hdr_stop),
        .hdr_adc_conv_in_i(hdr_conv), .hdr_dac_start_in_i(hdr_start),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .aux_output_pin_o(aux_out),
        .adc_conv_o(conv), .buf_addr_o(buf_addr), .dac_update_o(upd)
    );
    dtp_ext_model dtp_ext_model_inst (
        .ref_clk_i(ref_clk), .aux_input_pin_o(aux_in),
        .hdr_acq_stop_in_o(hdr_stop), .hdr_adc_conv_in_o(hdr_conv),
        .hdr_dac_start_in_o(hdr_start)
    );

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    always @(negedge ref_clk) begin
        if (conv === 1'b1) begin
            nconv++;
            ba = buf_addr;
        end
        if (upd === 1'b1) begin
            nupd++;
            upd_at = dtp_ext_model_inst.cyc;
        end
    end

    // ------------------------------------------------------------------
    // Access tasks and closing report
    // ------------------------------------------------------------------
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic wr_reg(input logic [5:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [5:0] a, output logic [31:0] v);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        @(negedge ref_clk);
        v = rdata;
    endtask

    task automatic wait_lvl(input int b, input logic lv);
        int k;
        k = 0;
        @(negedge ref_clk);
        while (aux_out[b] !== lv) begin
            @(negedge ref_clk);
            k++;
            if (k > 12000) begin
                miscompares++;
                print_verdict();
            end
        end
    endtask

    task automatic pw(input int b, input logic lv, output int r);
        wait_lvl(b, lv);
        r = 0;
        while (aux_out[b] === lv && r < 3000) begin
            @(negedge ref_clk);
            r++;
        end
        if (r >= 3000) begin
            miscompares++;
            print_verdict();
        end
    endtask

    task automatic count(input int c, output int r);
        int n0;
        n0 = nconv;
        repeat (c) @(posedge ref_clk);
        r = nconv - n0;
    endtask

    initial begin
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd_reg(`DTP_REG_AI_SEL, d);
        `CHK("stop_src", 3'h2, d[2:0])
        `CHK("conv_src", 3'h0, d[6:4])
        rd_reg(6'h3C, d);
        `CHK("unmapped", 32'h00000000, d)
        wr_reg(`DTP_REG_CTRL, 32'h1 << `DTP_CTRL_EXT_CONV);
        wr_reg(`DTP_REG_OUT_SEL, 32'h4);
        wr_reg(`DTP_REG_CMD, 32'h1 << `DTP_CMD_AI_ARM);
        for (s = 0; s < 7; s++) begin
            wr_reg(`DTP_REG_AI_SEL, 32'h5002 | (s << 4));
            n = nconv;
            fork
                dtp_ext_model_inst.strobe((s == 6) ? 7 : s, 500);
                pw(0, 1'b1, w);
            join
            `CHK("conv_count", n + 1, nconv)
            `CHK("conv_width", 1, w)
        end
        dtp_ext_model_inst.flip(1, 500);
        wr_reg(`DTP_REG_AI_SEL, 32'h5092);
        n = nconv;
        dtp_ext_model_inst.strobe(1, 500);
        repeat (10) @(posedge ref_clk);
        `CHK("conv_falling", n + 1, nconv)
        wr_reg(`DTP_REG_CMD, 32'h1 << `DTP_CMD_AI_DISARM);
        wr_reg(`DTP_REG_AI_SEL, 32'h5002);
        wr_reg(`DTP_REG_POST, 32'h2);
        wr_reg(`DTP_REG_CTRL, 32'h6);
        wr_reg(`DTP_REG_OUT_SEL, 32'hA9);
        wr_reg(`DTP_REG_CMD, 32'h1);
        fork
            dtp_ext_model_inst.strobe(0, 500);
            pw(2, 1'b1, w);
        join
        `CHK("scan_begin_width", 5, w)
        d[12:0] = ba + 13'h1;
        dtp_ext_model_inst.strobe(0, 500);
        repeat (10) @(posedge ref_clk);
        `CHK("buf_index", d[12:0], ba)
        fork
            dtp_ext_model_inst.strobe(2, 0);
            pw(0, 1'b1, w);
        join
        `CHK("stop_width", 5, w)
        rd_reg(`DTP_REG_STATUS, d);
        `CHK("acq_post", 3'b100, d[7:5])
        dtp_ext_model_inst.strobe(0, 500);
        fork
            dtp_ext_model_inst.strobe(0, 500);
            pw(1, 1'b1, w);
        join
        `CHK("done_width", 5, w)
        n = nconv;
        dtp_ext_model_inst.strobe(0, 500);
        repeat (10) @(posedge ref_clk);
        `CHK("after_done", n, nconv)
        wr_reg(`DTP_REG_CTRL, 32'h80);
        wr_reg(`DTP_REG_AI_DIV, 32'h9);
        wr_reg(`DTP_REG_CMD, 32'h1);
        count(3000, n);
        `CHK("pacer_runs", 1'b1, n > 3)
        dtp_ext_model_inst.flip(0, 0);
        count(600, n);
        count(3000, n);
        `CHK("gate_holds", 0, n)
        dtp_ext_model_inst.flip(0, 0);
        wr_reg(`DTP_REG_CTRL, 32'h8);
        count(600, n);
        count(3000, n);
        `CHK("sw_gate", 0, n)
        wr_reg(`DTP_REG_CHANS, 32'h3);
        wr_reg(`DTP_REG_OUT_SEL, 32'hC0);
        wr_reg(`DTP_REG_CTRL, 32'h80);
        pw(2, 1'b1, w);
        `CHK("sh_span", 1'b1, w >= 1000 && w <= 1010)
        wait_lvl(2, 1'b1);
        dtp_ext_model_inst.flip(0, 0);
        count(3000, s);
        `CHK("scan_finishes", 1'b1, s >= 2 && s <= 3)
        count(3000, s);
        `CHK("scan_held", 0, s)
        dtp_ext_model_inst.flip(0, 0);
        wr_reg(`DTP_REG_CHANS, 32'h1);
        wr_reg(`DTP_REG_CTRL, 32'h10);
        count(600, s);
        count(3000, s);
        `CHK("tb_stalled", 1'b1, s <= 1)
        dtp_ext_model_inst.tb_run = 1'b1;
        count(3000, s);
        `CHK("tb_running", 1'b1, s > 3)
        wr_reg(`DTP_REG_CMD, 32'h2);
        wr_reg(`DTP_REG_CTRL, 32'h100);
        wr_reg(`DTP_REG_OUT_SEL, 32'h3E);
        wr_reg(`DTP_REG_CMD, 32'h4);
        n = nupd;
        dtp_ext_model_inst.strobe(3, 10000);
        repeat (20) @(posedge ref_clk);
        `CHK("upd_held", n, nupd)
        fork
            dtp_ext_model_inst.strobe(4, 0);
            pw(0, 1'b1, w);
        join
        `CHK("ao_start_width", 5, w)
        rd_reg(`DTP_REG_STATUS, d);
        `CHK("ao_run", 3'b100, d[10:8])
        fork
            dtp_ext_model_inst.strobe(3, 10000);
            pw(1, 1'b1, w);
        join
        `CHK("upd_width", 23, w)
        `CHK("upd_count", n + 1, nupd)
        s = upd_at - dtp_ext_model_inst.edge_cyc;
        `CHK("upd_fast", 1'b1, s >= 1 && s <= 10)
        wr_reg(`DTP_REG_AO_SEL, 32'h1034);
        wait_lvl(1, 1'b1);
        fork
            dtp_ext_model_inst.strobe(3, 10000);
            pw(1, 1'b0, w);
        join
        `CHK("upd_inv_width", 23, w)
        wr_reg(`DTP_REG_AO_SEL, 32'h0534);
        wr_reg(`DTP_REG_AO_DIV, 32'h3);
        n = nupd;
        wr_reg(`DTP_REG_CTRL, 32'h40);
        repeat (600) @(posedge ref_clk);
        `CHK("ao_tb_running", 1'b1, nupd - n > 3)
        dtp_ext_model_inst.tb_run = 1'b0;
        repeat (100) @(posedge ref_clk);
        n = nupd;
        repeat (600) @(posedge ref_clk);
        `CHK("ao_tb_stalled", n, nupd)
        print_verdict();
    end
endmodule
`default_nettype wire
